// >>> hdl/cpu_regs_pkg.sv
/*
  Constants, register offsets, datapath command codes and sequencer states
  for the CPU status and pointer register block.
  Assumes a single CPU clock and a synchronous active-low reset.
*/
package cpu_regs_pkg;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] ADDR_ACC = 4'h0;
  localparam logic [3:0] ADDR_AUX = 4'h1;
  localparam logic [3:0] ADDR_PSW = 4'h2;
  localparam logic [3:0] ADDR_SP = 4'h3;
  localparam logic [3:0] ADDR_DPL = 4'h4;
  localparam logic [3:0] ADDR_DPH = 4'h5;
  localparam logic [3:0] ADDR_PCL = 4'h6;
  localparam logic [3:0] ADDR_PCH = 4'h7;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  // ----------------------------------------------------------------
  // Status word layout and reset values
  // ----------------------------------------------------------------
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_USER = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_RSVD = 1;
  localparam int PSW_PAR = 0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] DATA_POINTER_REG_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MULDIV_CYCLES = 4;
  localparam logic [1:0] MULDIV_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Datapath commands
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_NONE = 5'h00;
  localparam logic [4:0] OP_ADD = 5'h01;
  localparam logic [4:0] OP_ADDC = 5'h02;
  localparam logic [4:0] OP_SUBB = 5'h03;
  localparam logic [4:0] OP_MUL = 5'h04;
  localparam logic [4:0] OP_DIV = 5'h05;
  localparam logic [4:0] OP_PUSH = 5'h06;
  localparam logic [4:0] OP_POP = 5'h07;
  localparam logic [4:0] OP_CALL = 5'h08;
  localparam logic [4:0] OP_RET = 5'h09;
  localparam logic [4:0] OP_DATA_POINTER_REG_LOAD = 5'h0a;
  localparam logic [4:0] OP_DATA_POINTER_REG_INC = 5'h0b;
  localparam logic [4:0] OP_BIT_MOV = 5'h0c;
  localparam logic [4:0] OP_BIT_AND = 5'h0d;
  localparam logic [4:0] OP_BIT_OR = 5'h0e;
  localparam logic [4:0] OP_BIT_CPL = 5'h0f;
  localparam logic [4:0] OP_ACC_LOAD = 5'h10;
  localparam logic [4:0] OP_JMP_REL = 5'h11;
  localparam logic [4:0] OP_JMP_LONG = 5'h12;
  localparam logic [4:0] OP_JMP_IND = 5'h13;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } seq_state_type;

endpackage

// >>> hdl/arith_unit.sv
/*
  Combinational byte arithmetic: add, add with carry, subtract with borrow,
  multiply and divide, with carry, half carry and signed overflow.
  Assumes the caller registers every result it keeps.
*/
module arith_unit
  import cpu_regs_pkg::*;
(
  input wire logic [4:0] op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  output logic [7:0] res_lo_o,
  output logic [7:0] res_hi_o,
  output logic carry_o,
  output logic half_o,
  output logic ovf_o
);

  // Subtraction is a plus inverted b plus inverted borrow.
  wire is_sub = (op_i == OP_SUBB);
  wire [7:0] b_eff = is_sub ? ~b_i : b_i;
  wire cin = (op_i == OP_ADD) ? 1'b0 : (is_sub ? ~carry_i : carry_i);
  wire [4:0] nib = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  wire [8:0] sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, cin};
  wire [15:0] prod = a_i * b_i;
  wire div_zero = (b_i == 8'h00);
  // A zero divisor leaves all ones and the dividend, flagged by overflow.
  wire [7:0] quot = div_zero ? 8'hff : a_i / b_i;
  wire [7:0] rem = div_zero ? a_i : a_i % b_i;
  wire add_ovf = (a_i[7] == b_eff[7]) && (sum[7] != a_i[7]);

  always_comb begin
    res_lo_o = sum[7:0];
    res_hi_o = 8'h00;
    carry_o = is_sub ? ~sum[8] : sum[8];
    half_o = is_sub ? ~nib[4] : nib[4];
    ovf_o = add_ovf;
    case (op_i)
      OP_MUL: begin
        res_lo_o = prod[7:0];
        res_hi_o = prod[15:8];
        carry_o = 1'b0;
        ovf_o = (prod[15:8] != 8'h00);
      end
      OP_DIV: begin
        res_lo_o = quot;
        res_hi_o = rem;
        carry_o = 1'b0;
        ovf_o = div_zero;
      end
      default: begin
        res_hi_o = 8'h00;
      end
    endcase
  end

endmodule

// >>> hdl/cpu_status_regs.sv
/*
  Accumulator, operand register, status word, stack pointer, data pointer
  and program counter of a small 8-bit CPU.
  Assumes a sequencer issuing one command per cycle on the op port and
  software reaching the registers over a plain strobe port.
*/
// The placing of the registers and the plain strobed port were left to the implementer.

// Function
// - Carry at status bit 7 follows arithmetic and bit commands, and software writes.
// - Half carry at bit 6 marks carry or borrow at bit 3 on add and subtract.
// - Bit 5 is a user flag only software changes.
// - Bits 4 and 3 pick the register bank, software written only.
// - Overflow at bit 2 marks signed overflow of add and subtract, a product over 255 and a zero divisor.
// - Parity at bit 0 follows the accumulator every cycle, odd count reads one.
// - Carry acts as one-bit accumulator for bit logic and bit moves.
// - Accumulator is operand and destination of add, subtract, multiply, divide.
// - Operand register is second multiply/divide input and takes eight result bits.
// - Stack pointer holds the address of the last pushed byte.
// - Push and call raise the stack pointer, pop and return lower it.
// - Reset sets the stack pointer to seven.
// - Software may write the stack pointer anywhere in internal RAM.
// - Data pointer halves are separate registers; load and increment act on all 16 bits.
// - Data pointer is base of indirect jumps, table reads and external transfers.
// - An instruction is one to three bytes long.
// - Commands take one cycle except multiply and divide, which take four.
// - Fetch normally advances two bytes per instruction cycle.
// - Relative jumps add a signed offset to the program counter, unpaged.
// - Long jumps load a full 16-bit address.
module cpu_status_regs
  import cpu_regs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic op_valid_i,
  input wire logic [4:0] op_code_i,
  input wire logic [15:0] op_data_i,
  input wire logic bit_in_i,
  input wire logic fetch_step_i,
  input wire logic [1:0] fetch_len_i,
  output logic op_ready_o,
  output logic op_done_o,
  output logic [7:0] acc_o,
  output logic [7:0] aux_o,
  output logic [7:0] psw_o,
  output logic [7:0] stack_addr_o,
  output logic [15:0] data_pointer_o,
  output logic [4:0] bank_base_o,
  output logic [15:0] code_addr_o,
  output logic [15:0] fetch_addr_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] base_plus(input logic [15:0] base, input logic [7:0] idx);
    base_plus = base + {8'h00, idx};
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] acc_q, acc_d, aux_q, aux_d, psw_q, psw_d, stack_pointer_reg_q, sp_d;
  logic [7:0] data_pointer_low_q, dpl_d, data_pointer_high_q, dph_d, rdata_q;
  logic [15:0] pc_q, pc_d, code_addr_q;
  logic [4:0] md_op_q;
  logic [7:0] md_a_q, md_b_q;
  logic [1:0] cnt_q;
  logic ready_q, done_q;
  logic [4:0] bank_base_q;
  seq_state_type st_q, st_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire busy = (st_q == ST_BUSY);
  wire take = op_valid_i && !busy;
  wire wr_acc = reg_wr_i && (reg_addr_i == ADDR_ACC);
  wire wr_aux = reg_wr_i && (reg_addr_i == ADDR_AUX);
  wire wr_psw = reg_wr_i && (reg_addr_i == ADDR_PSW);
  wire wr_sp = reg_wr_i && (reg_addr_i == ADDR_SP);
  wire wr_dpl = reg_wr_i && (reg_addr_i == ADDR_DPL);
  wire wr_dph = reg_wr_i && (reg_addr_i == ADDR_DPH);
  wire is_arith = (op_code_i == OP_ADD) || (op_code_i == OP_ADDC) || (op_code_i == OP_SUBB);
  wire is_muldiv = (op_code_i == OP_MUL) || (op_code_i == OP_DIV);
  wire md_finish = busy && (cnt_q == MULDIV_LAST);
  wire [15:0] data_pointer_reg_q = {data_pointer_high_q, data_pointer_low_q};
  wire [15:0] data_pointer_reg_inc = data_pointer_reg_q + 16'h0001;
  wire [15:0] data_pointer_reg_d = {dph_d, dpl_d};

  wire [4:0] alu_op = busy ? md_op_q : op_code_i;
  wire [7:0] alu_a = busy ? md_a_q : acc_q;
  wire [7:0] alu_b = busy ? md_b_q : op_data_i[7:0];
  wire [7:0] alu_lo, alu_hi;
  wire alu_cy, alu_ac, alu_ov;

  arith_unit u_arith (
    .op_i(alu_op),
    .a_i(alu_a),
    .b_i(alu_b),
    .carry_i(psw_q[PSW_CY]),
    .res_lo_o(alu_lo),
    .res_hi_o(alu_hi),
    .carry_o(alu_cy),
    .half_o(alu_ac),
    .ovf_o(alu_ov)
  );

  wire [7:0] rd_mux =
    (reg_addr_i == ADDR_ACC) ? acc_q :
    (reg_addr_i == ADDR_AUX) ? aux_q :
    (reg_addr_i == ADDR_PSW) ? psw_q :
    (reg_addr_i == ADDR_SP) ? stack_pointer_reg_q :
    (reg_addr_i == ADDR_DPL) ? data_pointer_low_q :
    (reg_addr_i == ADDR_DPH) ? data_pointer_high_q :
    (reg_addr_i == ADDR_PCL) ? pc_q[7:0] :
    (reg_addr_i == ADDR_PCH) ? pc_q[15:8] :
    (reg_addr_i == ADDR_STAT) ? {7'h00, busy} : 8'h00;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // A command's effect lands on top of a same-cycle software write, so a
  // hardware flag update is never lost to a racing store.
  always_comb begin
    acc_d = wr_acc ? reg_wdata_i : acc_q;
    aux_d = wr_aux ? reg_wdata_i : aux_q;
    if (take && is_arith) begin
      acc_d = alu_lo;
    end
    if (take && (op_code_i == OP_ACC_LOAD)) begin
      acc_d = op_data_i[7:0];
    end
    if (md_finish) begin
      acc_d = alu_lo;
      aux_d = alu_hi;
    end
  end

  always_comb begin
    psw_d = wr_psw ? reg_wdata_i : psw_q;
    if (take && is_arith) begin
      psw_d[PSW_CY] = alu_cy;
      psw_d[PSW_AC] = alu_ac;
      psw_d[PSW_OV] = alu_ov;
    end
    if (md_finish) begin
      psw_d[PSW_CY] = alu_cy;
      psw_d[PSW_OV] = alu_ov;
    end
    if (take) begin
      case (op_code_i)
        OP_BIT_MOV: psw_d[PSW_CY] = bit_in_i;
        OP_BIT_AND: psw_d[PSW_CY] = psw_d[PSW_CY] & bit_in_i;
        OP_BIT_OR: psw_d[PSW_CY] = psw_d[PSW_CY] | bit_in_i;
        OP_BIT_CPL: psw_d[PSW_CY] = ~psw_d[PSW_CY];
        default: psw_d[PSW_CY] = psw_d[PSW_CY];
      endcase
    end
    psw_d[PSW_PAR] = ^acc_d;
  end

  always_comb begin
    sp_d = wr_sp ? reg_wdata_i : stack_pointer_reg_q;
    if (take) begin
      case (op_code_i)
        OP_PUSH: sp_d = sp_d + 8'h01;
        OP_POP: sp_d = sp_d - 8'h01;
        OP_CALL: sp_d = sp_d + 8'h02;
        OP_RET: sp_d = sp_d - 8'h02;
        default: sp_d = sp_d;
      endcase
    end
  end

  always_comb begin
    dpl_d = wr_dpl ? reg_wdata_i : data_pointer_low_q;
    dph_d = wr_dph ? reg_wdata_i : data_pointer_high_q;
    if (take && (op_code_i == OP_DATA_POINTER_REG_LOAD)) begin
      {dph_d, dpl_d} = op_data_i;
    end
    if (take && (op_code_i == OP_DATA_POINTER_REG_INC)) begin
      {dph_d, dpl_d} = data_pointer_reg_inc;
    end
  end

  // A zero length is not an instruction and leaves the counter alone.
  always_comb begin
    pc_d = pc_q;
    if (fetch_step_i && (fetch_len_i != 2'h0)) begin
      pc_d = pc_q + {14'h0, fetch_len_i};
    end
    if (take) begin
      case (op_code_i)
        OP_JMP_REL: pc_d = pc_q + sext8(op_data_i[7:0]);
        OP_JMP_LONG: pc_d = op_data_i;
        OP_JMP_IND: pc_d = base_plus(data_pointer_reg_q, acc_q);
        default: pc_d = pc_d;
      endcase
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (take && is_muldiv) st_d = ST_BUSY;
      ST_BUSY: if (md_finish) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      acc_q <= ACC_RESET;
      aux_q <= ACC_RESET;
      psw_q <= PSW_RESET;
      stack_pointer_reg_q <= SP_RESET;
      {data_pointer_high_q, data_pointer_low_q} <= DATA_POINTER_REG_RESET;
      pc_q <= PC_RESET;
    end else begin
      acc_q <= acc_d;
      aux_q <= aux_d;
      psw_q <= psw_d;
      stack_pointer_reg_q <= sp_d;
      data_pointer_low_q <= dpl_d;
      data_pointer_high_q <= dph_d;
      pc_q <= pc_d;
    end
  end

  // Operands are frozen at the take so a software store mid-operation
  // cannot corrupt the result.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 2'h0;
      md_op_q <= OP_NONE;
      md_a_q <= 8'h00;
      md_b_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= (take && is_muldiv) ? 2'h1 : (busy ? cnt_q + 2'h1 : 2'h0);
      if (take && is_muldiv) begin
        md_op_q <= op_code_i;
        md_a_q <= acc_q;
        md_b_q <= aux_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      code_addr_q <= 16'h0000;
      bank_base_q <= 5'h00;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
      ready_q <= (st_d == ST_IDLE);
      done_q <= md_finish || (take && !is_muldiv);
      code_addr_q <= base_plus(data_pointer_reg_d, acc_d);
      bank_base_q <= {psw_d[PSW_BANK_HI], psw_d[PSW_BANK_LO], 3'h0};
    end
  end

  assign reg_rdata_o = rdata_q;
  assign op_ready_o = ready_q;
  assign op_done_o = done_q;
  assign acc_o = acc_q;
  assign aux_o = aux_q;
  assign psw_o = psw_q;
  assign stack_addr_o = stack_pointer_reg_q;
  assign data_pointer_o = data_pointer_reg_q;
  assign bank_base_o = bank_base_q;
  assign code_addr_o = code_addr_q;
  assign fetch_addr_o = pc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_sp_reset_value: assert property ($rose(reset_n_i) |-> stack_pointer_reg_q == SP_RESET)
    else $error("stack pointer not seven after reset");
  a_parity_tracks: assert property (##1 psw_q[PSW_PAR] == ^acc_q)
    else $error("parity does not match accumulator");
  a_push_incr: assert property (take && op_code_i == OP_PUSH && !wr_sp
    |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) + 8'h01)
    else $error("push did not raise stack pointer");
  a_pop_decr: assert property (take && op_code_i == OP_POP && !wr_sp
    |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) - 8'h01)
    else $error("pop did not lower stack pointer");
  a_call_incr: assert property (take && op_code_i == OP_CALL && !wr_sp
    |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) + 8'h02)
    else $error("call did not raise stack pointer by two");
  a_ret_decr: assert property (take && op_code_i == OP_RET && !wr_sp
    |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) - 8'h02)
    else $error("return did not lower stack pointer by two");
  a_user_flag_hold: assert property (!wr_psw |=> $stable(psw_q[PSW_USER]))
    else $error("user flag changed without a write");
  a_bank_hold: assert property (!wr_psw |=> $stable(psw_q[PSW_BANK_HI:PSW_BANK_LO]))
    else $error("bank select changed without a write");
  a_rsvd_hold: assert property (!wr_psw |=> $stable(psw_q[PSW_RSVD]))
    else $error("reserved bit changed without a write");
  a_muldiv_four: assert property (take && is_muldiv |=> !op_ready_o [*3] ##1 (op_done_o && op_ready_o))
    else $error("multiply or divide not four cycles");
  a_data_pointer_reg_inc: assert property (take && op_code_i == OP_DATA_POINTER_REG_INC && !wr_dpl && !wr_dph
    |=> data_pointer_o == $past(data_pointer_reg_q) + 16'h0001)
    else $error("data pointer increment wrong");
  a_carry_cpl: assert property (take && op_code_i == OP_BIT_CPL && !wr_psw
    |=> psw_q[PSW_CY] != $past(psw_q[PSW_CY]))
    else $error("carry complement failed");
  a_bit_move: assert property (take && op_code_i == OP_BIT_MOV
    |=> psw_q[PSW_CY] == $past(bit_in_i))
    else $error("bit move did not load carry");
  a_add_flags: assert property (take && op_code_i == OP_ADD
    |=> psw_q[PSW_CY] == ((9'($past(acc_q)) + 9'($past(op_data_i[7:0]))) > 9'h0ff)
    && psw_q[PSW_AC] == ((5'($past(acc_q[3:0])) + 5'($past(op_data_i[3:0]))) > 5'h0f))
    else $error("add carry or half carry wrong");
  a_sub_half: assert property (take && op_code_i == OP_SUBB
    |=> psw_q[PSW_AC] == (5'($past(acc_q[3:0])) < 5'($past(op_data_i[3:0])) + 5'($past(psw_q[PSW_CY]))))
    else $error("subtract half borrow wrong");
  a_add_ovf: assert property (take && op_code_i == OP_ADD
    |=> psw_q[PSW_OV] == ($past(acc_q[7]) == $past(op_data_i[7]) && acc_q[7] != $past(acc_q[7])))
    else $error("signed overflow wrong");
  a_table_base: assert property (##1 code_addr_o == base_plus(data_pointer_reg_q, acc_q))
    else $error("table address not data pointer plus accumulator");
  a_rel_jump: assert property (take && op_code_i == OP_JMP_REL
    |=> fetch_addr_o == $past(pc_q) + sext8($past(op_data_i[7:0])))
    else $error("relative jump target wrong");

  c_muldiv: cover property (take && op_code_i == OP_MUL ##4 op_done_o);
  c_push_pop: cover property (take && op_code_i == OP_PUSH ##1 take && op_code_i == OP_POP);
  c_long_jump: cover property (take && op_code_i == OP_JMP_LONG);
  c_div_zero: cover property (take && op_code_i == OP_DIV && aux_q == 8'h00);
  c_rel_jump: cover property (take && op_code_i == OP_JMP_REL);

endmodule

// >>> dv/seq_model.sv
/*
  Behavioural model of the instruction sequencer that drives the command
  and fetch ports of the CPU register block.
  Assumes it shares the block's clock and is called only after reset.
*/
module seq_model (
  input wire logic clk_i,
  input wire logic op_ready_i,
  input wire logic op_done_i,
  output logic op_valid_o,
  output logic [4:0] op_code_o,
  output logic [15:0] op_data_o,
  output logic bit_o,
  output logic fetch_step_o,
  output logic [1:0] fetch_len_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    op_valid_o = 1'b0;
    op_code_o = 5'h00;
    op_data_o = 16'h0000;
    bit_o = 1'b0;
    fetch_step_o = 1'b0;
    fetch_len_o = 2'h0;
  end

  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  // The operand lines are inverted on release, so a late sample by the
  // block shows up as a wrong result instead of a lucky match.
  task automatic issue(input logic [4:0] code, input logic [15:0] data, input logic bv, output int lat);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_code_o <= code;
    op_data_o <= data;
    bit_o <= bv;
    // Ready is registered, so its value just after an edge is what the next edge samples.
    #1;
    while (op_ready_i !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    op_code_o <= ~code;
    op_data_o <= ~data;
    bit_o <= ~bv;
    #1;
    lat = 0;
    while (op_done_i !== 1'b1 && lat < 8) begin
      @(posedge clk_i);
      #1;
      lat++;
    end
  endtask

  // ----------------------------------------------------------------
  // Fetch step
  // ----------------------------------------------------------------
  task automatic step(input logic [1:0] len);
    @(posedge clk_i);
    fetch_step_o <= 1'b1;
    fetch_len_o <= len;
    @(posedge clk_i);
    fetch_step_o <= 1'b0;
    fetch_len_o <= ~len;
    #1;
  endtask
endmodule

// >>> dv/testbench.sv
/*
  Self-checking testbench for the CPU status and pointer register block.
  Assumes the sequencer model in seq_model.sv and the package constants.
*/
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench
  import cpu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, reset_n, reg_wr, reg_rd, op_valid, bit_in, fetch_step, op_ready, op_done;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, acc, aux, program_status_word, stack_addr;
  logic [4:0] op_code, bank_base;
  logic [15:0] op_data, data_pointer_reg, code_addr, fetch_addr;
  logic [1:0] fetch_len;
  int n_mismatch = 0;
  int check_count = 0;
  int lat;
  logic [4:0] alu_op [8] = '{OP_ADD, OP_ADD, OP_SUBB, OP_ADDC, OP_BIT_MOV, OP_BIT_OR, OP_BIT_AND, OP_BIT_CPL};
  logic [7:0] alu_arg [8] = '{8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic alu_bit [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [15:0] alu_exp [8] = '{16'h8077, 16'h00b6, 16'hfff2, 16'h00f2, 16'h0072, 16'h00f2, 16'h0072, 16'h00f2};
  logic [4:0] md_op [3] = '{OP_MUL, OP_DIV, OP_DIV};
  logic [15:0] md_in [3] = '{16'h1020, 16'h6407, 16'h5a00};
  logic [17:0] md_exp [3] = '{{16'h0002, 2'b01}, {16'h0e02, 2'b00}, {16'hff5a, 2'b01}};
  logic [4:0] sp_op [6] = '{OP_PUSH, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_POP};
  logic [7:0] sp_exp [6] = '{8'h21, 8'h22, 8'h21, 8'h23, 8'h21, 8'h20};

  always #50 clk_sys = ~clk_sys;

  cpu_status_regs i_dut (
    .clk_sys_i(clk_sys), .reset_n_i(reset_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .op_valid_i(op_valid),
    .op_code_i(op_code), .op_data_i(op_data), .bit_in_i(bit_in), .fetch_step_i(fetch_step),
    .fetch_len_i(fetch_len), .op_ready_o(op_ready), .op_done_o(op_done), .acc_o(acc), .aux_o(aux),
    .psw_o(program_status_word), .stack_addr_o(stack_addr), .data_pointer_o(data_pointer_reg), .bank_base_o(bank_base),
    .code_addr_o(code_addr), .fetch_addr_o(fetch_addr)
  );

  seq_model i_seq (
    .clk_i(clk_sys), .op_ready_i(op_ready), .op_done_i(op_done), .op_valid_o(op_valid),
    .op_code_o(op_code), .op_data_o(op_data), .bit_o(bit_in), .fetch_step_o(fetch_step),
    .fetch_len_o(fetch_len)
  );

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(ADDR_SP, SP_RESET);
    reg_write(ADDR_PSW, 8'hff);
    rd_chk(ADDR_PSW, 8'hfe);
    for (int b = 0; b < 4; b++) begin
      reg_write(ADDR_PSW, {3'b000, 2'(b), 3'b000});
      `CHK(bank_base, {2'(b), 3'b000})
    end
    // User flag, bank 2 and the reserved bit are set so side effects on them show.
    reg_write(ADDR_PSW, 8'h32);
    reg_write(ADDR_ACC, 8'h7f);
    rd_chk(ADDR_PSW, 8'h33);
    for (int i = 0; i < 8; i++) begin
      i_seq.issue(alu_op[i], {8'h00, alu_arg[i]}, alu_bit[i], lat);
      `CHK(lat, 0)
      `CHK({acc, program_status_word}, alu_exp[i])
    end
    for (int i = 0; i < 3; i++) begin
      reg_write(ADDR_ACC, md_in[i][15:8]);
      reg_write(ADDR_AUX, md_in[i][7:0]);
      i_seq.issue(md_op[i], 16'h0000, 1'b0, lat);
      `CHK(lat, MULDIV_CYCLES - 1)
      `CHK({acc, aux, program_status_word[PSW_CY], program_status_word[PSW_OV]}, md_exp[i])
    end
    reg_write(ADDR_SP, 8'h20);
    for (int i = 0; i < 6; i++) begin
      i_seq.issue(sp_op[i], 16'h0000, 1'b0, lat);
      `CHK(stack_addr, sp_exp[i])
    end
    rd_chk(ADDR_SP, 8'h20);
    reg_write(ADDR_DPL, 8'hff);
    reg_write(ADDR_DPH, 8'h12);
    `CHK(data_pointer_reg, 16'h12ff)
    i_seq.issue(OP_DATA_POINTER_REG_INC, 16'h0000, 1'b0, lat);
    `CHK(data_pointer_reg, 16'h1300)
    rd_chk(ADDR_DPL, 8'h00);
    rd_chk(ADDR_DPH, 8'h13);
    i_seq.issue(OP_DATA_POINTER_REG_LOAD, 16'habcd, 1'b0, lat);
    i_seq.issue(OP_JMP_IND, 16'h0000, 1'b0, lat);
    `CHK(fetch_addr, 16'haccc)
    `CHK(code_addr, 16'haccc)
    // The program counter halves are read-only from software.
    reg_write(ADDR_PCL, 8'h00);
    rd_chk(ADDR_PCL, 8'hcc);
    i_seq.step(2'd3);
    `CHK(fetch_addr, 16'haccf)
    i_seq.issue(OP_JMP_REL, 16'h00fe, 1'b0, lat);
    `CHK(fetch_addr, 16'haccd)
    i_seq.issue(OP_JMP_LONG, 16'hffff, 1'b0, lat);
    `CHK(fetch_addr, 16'hffff)
    reg_write(4'hf, 8'h55);
    rd_chk(4'hf, 8'h00);
    report_and_stop;
  end

  // The sequence needs about 115 cycles; this limit leaves wide margin.
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop;
  end
endmodule
